// ===== src/gpei_port.sv
// GPIO port with remap, configuration lock and edge interrupt controller.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none
module gpei_port #(
  parameter int NUM_PORTS = 8
) (
  input  wire logic                                     pclk,
  input  wire logic                                     presetn,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [7:0]                               paddr,
  input  wire logic [31:0]                              pwdata,
  output var  logic [31:0]                              prdata,
  output var  logic                                     pready,
  output var  logic                                     pslverr,
  input  wire logic [gpei_pkg::NUM_PINS-1:0]            pin_in,
  output var  logic [gpei_pkg::NUM_PINS-1:0]            pin_out,
  output var  logic [gpei_pkg::NUM_PINS-1:0]            pin_oe_n,
  output var  logic [gpei_pkg::NUM_PINS-1:0]            pin_pu,
  output var  logic [gpei_pkg::NUM_PINS-1:0]            pin_pd,
  input  wire logic [gpei_pkg::AF_SRCS*gpei_pkg::NUM_PINS-1:0] af_src,
  input  wire logic [(NUM_PORTS-1)*gpei_pkg::NUM_PINS-1:0]     other_ports,
  input  wire logic [gpei_pkg::INT_LINES-1:0]           int_evt,
  output var  logic [gpei_pkg::NUM_LINES-1:0]           evt_out,
  output var  logic                                     irq
);
  localparam int NP = gpei_pkg::NUM_PINS;
  localparam int NL = gpei_pkg::NUM_LINES;

  logic [31:0]           mode_ff;
  logic [NP-1:0]         otype_ff;
  logic [31:0]           pull_ff;
  logic [NP-1:0]         odr_ff;
  logic [31:0]           afmap_ff;
  logic [NP-1:0]         idr_ff;
  logic [NL-1:0]         rise_ff;
  logic [NL-1:0]         fall_ff;
  logic [NL-1:0]         ien_ff;
  logic [NL-1:0]         een_ff;
  logic [63:0]           src_ff;
  gpei_pkg::gpei_lock_t  lock_ff;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;
  logic [NP-1:0]         pin_out_ff;
  logic [NP-1:0]         pin_oe_n_ff;
  logic [NP-1:0]         pin_pu_ff;
  logic [NP-1:0]         pin_pd_ff;

  logic [31:0]           nxt_mode;
  logic [NP-1:0]         nxt_otype;
  logic [31:0]           nxt_pull;
  logic [NP-1:0]         nxt_odr;
  logic [31:0]           nxt_afmap;
  logic [NP-1:0]         nxt_idr;
  logic [NL-1:0]         nxt_rise;
  logic [NL-1:0]         nxt_fall;
  logic [NL-1:0]         nxt_ien;
  logic [NL-1:0]         nxt_een;
  logic [63:0]           nxt_src;
  gpei_pkg::gpei_lock_t  nxt_lock;
  logic [31:0]           nxt_prdata;
  logic                  nxt_pready;
  logic                  nxt_pslverr;
  logic [NP-1:0]         nxt_pin_out;
  logic [NP-1:0]         nxt_pin_oe_n;
  logic [NP-1:0]         nxt_pin_pu;
  logic [NP-1:0]         nxt_pin_pd;

  logic                  wr_en;
  logic                  locked;
  logic                  tick;
  logic [NP*NUM_PORTS-1:0] all_ports;

  gpei_edge_if eif ();

  gpei_edge_ctl u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .eif     (eif)
  );

  // Output refresh strobe bounds the toggle rate seen at the pins.
  gpei_rate_div #(
    .DIV (gpei_pkg::TOGGLE_CYC)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // A write takes effect on the access edge where pready is high.
  assign wr_en  = psel && penable && pwrite && pready_ff;
  assign locked = (lock_ff == gpei_pkg::LK_LOCKED);
  assign all_ports = {other_ports, idr_ff};

  // Per pin output, enable and pull computation.
  genvar i;
  generate
    for (i = 0; i < NP; i++)
    begin : g_pin
      logic [1:0] m;
      logic [1:0] sel;
      logic       val;
      logic       drv;
      assign m   = mode_ff[2*i +: 2];
      assign sel = afmap_ff[2*i +: 2];
      assign val = (m == gpei_pkg::MODE_AF) ? af_src[32'(sel)*NP + i] : odr_ff[i];
      assign drv = (m == gpei_pkg::MODE_OUT) || (m == gpei_pkg::MODE_AF);
      // Open drain only ever pulls low; a high level releases the pin.
      assign nxt_pin_out[i]  = tick ? (val && !otype_ff[i]) : pin_out_ff[i];
      assign nxt_pin_oe_n[i] = tick ? !(drv && (!otype_ff[i] || !val))
                                    : pin_oe_n_ff[i];
      assign nxt_pin_pu[i]   = (m == gpei_pkg::MODE_IN) &&
                               (pull_ff[2*i +: 2] == gpei_pkg::PULL_UP);
      assign nxt_pin_pd[i]   = (m == gpei_pkg::MODE_IN) &&
                               (pull_ff[2*i +: 2] == gpei_pkg::PULL_DN);
      // Analog pins read as zero; their edge lines can see an edge only when the mode switches into or out of analog.
      assign nxt_idr[i]      = (m != gpei_pkg::MODE_ANA) && pin_in[i];
    end
  endgenerate

  // Source selection of the pin lines; an out of range port reads zero.
  genvar l;
  generate
    for (l = 0; l < gpei_pkg::PIN_LINES; l++)
    begin : g_src
      logic [3:0] ps;
      assign ps = src_ff[4*l +: 4];
      assign eif.lines[l] = (32'(ps) < NUM_PORTS) ?
                            all_ports[32'(ps)*NP + l] : 1'b0;
    end
  endgenerate

  assign eif.lines[NL-1:gpei_pkg::PIN_LINES] = int_evt;
  assign eif.rise = rise_ff;
  assign eif.fall = fall_ff;
  assign eif.ien  = ien_ff;
  assign eif.een  = een_ff;
  assign eif.clr  = (wr_en && paddr == gpei_pkg::OFS_PCLR) ? pwdata[NL-1:0]
                                                           : gpei_pkg::RST_LINES;

  // Register writes and the lock sequencer. Lock freezes mode and remap.
  always_comb
  begin
    nxt_mode  = mode_ff;
    nxt_otype = otype_ff;
    nxt_pull  = pull_ff;
    nxt_odr   = odr_ff;
    nxt_afmap = afmap_ff;
    nxt_rise  = rise_ff;
    nxt_fall  = fall_ff;
    nxt_ien   = ien_ff;
    nxt_een   = een_ff;
    nxt_src   = src_ff;
    nxt_lock  = lock_ff;
    if (wr_en)
    begin
      case (paddr)
        gpei_pkg::OFS_MODE:  if (!locked) nxt_mode = pwdata;
        gpei_pkg::OFS_OTYPE: nxt_otype = pwdata[NP-1:0];
        gpei_pkg::OFS_PULL:  nxt_pull = pwdata;
        gpei_pkg::OFS_ODR:   nxt_odr = pwdata[NP-1:0];
        gpei_pkg::OFS_AFMAP: if (!locked) nxt_afmap = pwdata;
        gpei_pkg::OFS_RISE:  nxt_rise = pwdata[NL-1:0];
        gpei_pkg::OFS_FALL:  nxt_fall = pwdata[NL-1:0];
        gpei_pkg::OFS_IEN:   nxt_ien = pwdata[NL-1:0];
        gpei_pkg::OFS_EEN:   nxt_een = pwdata[NL-1:0];
        gpei_pkg::OFS_SRC0:  nxt_src[31:0] = pwdata;
        gpei_pkg::OFS_SRC1:  nxt_src[63:32] = pwdata;
        gpei_pkg::OFS_LOCK:
        begin
          case (lock_ff)
            gpei_pkg::LK_OPEN:
              nxt_lock = (pwdata == gpei_pkg::LOCK_KEY1) ? gpei_pkg::LK_ARMED
                                                         : gpei_pkg::LK_OPEN;
            gpei_pkg::LK_ARMED:
              nxt_lock = (pwdata == gpei_pkg::LOCK_KEY2) ? gpei_pkg::LK_LOCKED
                                                         : gpei_pkg::LK_OPEN;
            gpei_pkg::LK_LOCKED: nxt_lock = gpei_pkg::LK_LOCKED;
            default:             nxt_lock = gpei_pkg::LK_OPEN;
          endcase
        end
        default: nxt_lock = lock_ff;
      endcase
    end
  end

  // Read data and error are prepared in the setup cycle: zero wait states.
  always_comb
  begin
    nxt_pready  = psel && !penable;
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = 1'b0;
    case (paddr)
      gpei_pkg::OFS_MODE:  nxt_prdata = mode_ff;
      gpei_pkg::OFS_OTYPE: nxt_prdata = {16'h0000, otype_ff};
      gpei_pkg::OFS_PULL:  nxt_prdata = pull_ff;
      gpei_pkg::OFS_IDR:   nxt_prdata = {16'h0000, idr_ff};
      gpei_pkg::OFS_ODR:   nxt_prdata = {16'h0000, odr_ff};
      gpei_pkg::OFS_AFMAP: nxt_prdata = afmap_ff;
      gpei_pkg::OFS_LOCK:  nxt_prdata = {31'h00000000, locked};
      gpei_pkg::OFS_RISE:  nxt_prdata = {8'h00, rise_ff};
      gpei_pkg::OFS_FALL:  nxt_prdata = {8'h00, fall_ff};
      gpei_pkg::OFS_IEN:   nxt_prdata = {8'h00, ien_ff};
      gpei_pkg::OFS_EEN:   nxt_prdata = {8'h00, een_ff};
      gpei_pkg::OFS_PEND:  nxt_prdata = {8'h00, eif.pend};
      gpei_pkg::OFS_PCLR:  nxt_prdata = 32'h00000000;
      gpei_pkg::OFS_SRC0:  nxt_prdata = src_ff[31:0];
      gpei_pkg::OFS_SRC1:  nxt_prdata = src_ff[63:32];
      default:             nxt_pslverr = 1'b1;
    endcase
    if (!(psel && !penable))
    begin
      nxt_prdata  = prdata_ff;
      nxt_pslverr = pslverr_ff;
    end
  end

  // All state registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff     <= gpei_pkg::RST_WORD;
      otype_ff    <= gpei_pkg::RST_PINS;
      pull_ff     <= gpei_pkg::RST_WORD;
      odr_ff      <= gpei_pkg::RST_PINS;
      afmap_ff    <= gpei_pkg::RST_WORD;
      idr_ff      <= gpei_pkg::RST_PINS;
      rise_ff     <= gpei_pkg::RST_LINES;
      fall_ff     <= gpei_pkg::RST_LINES;
      ien_ff      <= gpei_pkg::RST_LINES;
      een_ff      <= gpei_pkg::RST_LINES;
      src_ff      <= {gpei_pkg::RST_WORD, gpei_pkg::RST_WORD};
      lock_ff     <= gpei_pkg::LK_OPEN;
      prdata_ff   <= gpei_pkg::RST_WORD;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      pin_out_ff  <= gpei_pkg::RST_PINS;
      pin_oe_n_ff <= ~gpei_pkg::RST_PINS;
      pin_pu_ff   <= gpei_pkg::RST_PINS;
      pin_pd_ff   <= gpei_pkg::RST_PINS;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      otype_ff    <= nxt_otype;
      pull_ff     <= nxt_pull;
      odr_ff      <= nxt_odr;
      afmap_ff    <= nxt_afmap;
      idr_ff      <= nxt_idr;
      rise_ff     <= nxt_rise;
      fall_ff     <= nxt_fall;
      ien_ff      <= nxt_ien;
      een_ff      <= nxt_een;
      src_ff      <= nxt_src;
      lock_ff     <= nxt_lock;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      pin_out_ff  <= nxt_pin_out;
      pin_oe_n_ff <= nxt_pin_oe_n;
      pin_pu_ff   <= nxt_pin_pu;
      pin_pd_ff   <= nxt_pin_pd;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign pin_out  = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;
  assign pin_pu   = pin_pu_ff;
  assign pin_pd   = pin_pd_ff;
  assign evt_out  = eif.evt;
  assign irq      = eif.irq;
endmodule
`default_nettype wire

// ===== src/gpei_pkg.sv
// Shared constants and types for the GPIO port with edge interrupt controller.
`default_nettype none
package gpei_pkg;
  // Port geometry.
  localparam int NUM_PINS  = 16;
  localparam int NUM_LINES = 24;
  localparam int PIN_LINES = 16;
  localparam int INT_LINES = 8;
  localparam int AF_SRCS   = 4;
  localparam int SEL_W     = 4;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_MODE  = 8'h00;
  localparam logic [7:0] OFS_OTYPE = 8'h04;
  localparam logic [7:0] OFS_PULL  = 8'h08;
  localparam logic [7:0] OFS_IDR   = 8'h0C;
  localparam logic [7:0] OFS_ODR   = 8'h10;
  localparam logic [7:0] OFS_AFMAP = 8'h14;
  localparam logic [7:0] OFS_LOCK  = 8'h18;
  localparam logic [7:0] OFS_RISE  = 8'h20;
  localparam logic [7:0] OFS_FALL  = 8'h24;
  localparam logic [7:0] OFS_IEN   = 8'h28;
  localparam logic [7:0] OFS_EEN   = 8'h2C;
  localparam logic [7:0] OFS_PEND  = 8'h30;
  localparam logic [7:0] OFS_PCLR  = 8'h34;
  localparam logic [7:0] OFS_SRC0  = 8'h38;
  localparam logic [7:0] OFS_SRC1  = 8'h3C;

  // Two-bit pin mode and pull field codes.
  localparam logic [1:0] MODE_IN   = 2'h0;
  localparam logic [1:0] MODE_OUT  = 2'h1;
  localparam logic [1:0] MODE_AF   = 2'h2;
  localparam logic [1:0] MODE_ANA  = 2'h3;
  localparam logic [1:0] PULL_UP   = 2'h1;
  localparam logic [1:0] PULL_DN   = 2'h2;

  // Lock key words, written in this order to the lock register.
  localparam logic [31:0] LOCK_KEY1 = 32'h0000005A;
  localparam logic [31:0] LOCK_KEY2 = 32'h000000A5;

  // Reset values.
  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic [23:0] RST_LINES = 24'h000000;
  localparam logic [15:0] RST_PINS  = 16'h0000;

  // Output refresh rate: least refresh period rounds up to whole cycles.
  localparam longint CLK_HZ     = 125_000_000;
  localparam longint TOGGLE_HZ  = 16_000_000;
  localparam int     TOGGLE_CYC = int'((CLK_HZ + TOGGLE_HZ - 1) / TOGGLE_HZ);

  // Lock sequencer states.
  typedef enum logic [2:0] {
    LK_OPEN   = 3'b001,
    LK_ARMED  = 3'b010,
    LK_LOCKED = 3'b100
  } gpei_lock_t;
endpackage
`default_nettype wire

// ===== src/gpei_edge_if.sv
// Carrier between the port register file and the edge interrupt controller.
`default_nettype none
interface gpei_edge_if;
  logic [gpei_pkg::NUM_LINES-1:0] lines;
  logic [gpei_pkg::NUM_LINES-1:0] rise;
  logic [gpei_pkg::NUM_LINES-1:0] fall;
  logic [gpei_pkg::NUM_LINES-1:0] ien;
  logic [gpei_pkg::NUM_LINES-1:0] een;
  logic [gpei_pkg::NUM_LINES-1:0] clr;
  logic [gpei_pkg::NUM_LINES-1:0] pend;
  logic [gpei_pkg::NUM_LINES-1:0] evt;
  logic                           irq;

  modport ctl (input lines, rise, fall, ien, een, clr, output pend, evt, irq);
  modport cfg (output lines, rise, fall, ien, een, clr, input pend, evt, irq);
endinterface
`default_nettype wire

// ===== src/gpei_rate_div.sv
// Divider that gives a one-cycle enable pulse every DIV clock cycles.
`default_nettype none
module gpei_rate_div #(
  parameter int DIV = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output var  logic tick
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        tick_ff;
  logic        nxt_tick;

  // Count down and pulse when the count wraps.
  always_comb
  begin
    nxt_tick = (cnt_ff == 16'h0000);
    nxt_cnt  = nxt_tick ? 16'(DIV - 1) : cnt_ff - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

// ===== src/gpei_edge_ctl.sv
// Edge detector lines with pending flags, event pulses and interrupt output.
`default_nettype none
module gpei_edge_ctl (
  input  wire logic pclk,
  input  wire logic presetn,
  gpei_edge_if.ctl  eif
);
  localparam int N = gpei_pkg::NUM_LINES;

  logic [N-1:0] prev_ff;
  logic [N-1:0] pend_ff;
  logic [N-1:0] evt_ff;
  logic         irq_ff;
  logic         armed_ff;
  logic [N-1:0] hit;
  logic [N-1:0] nxt_pend;
  logic [N-1:0] nxt_evt;
  logic         nxt_irq;

  // Each line is compared with its value one pclk earlier, so a pulse of a
  // single pclk cycle, far shorter than a divided peripheral clock, is seen.
  genvar k;
  generate
    for (k = 0; k < N; k++)
    begin : g_line
      assign hit[k] = armed_ff &&
        ((eif.rise[k] && eif.lines[k] && !prev_ff[k]) ||
         (eif.fall[k] && !eif.lines[k] && prev_ff[k]));
    end
  endgenerate

  // A new edge wins over a clear in the same cycle.
  always_comb
  begin
    nxt_pend = (pend_ff & ~eif.clr) | hit;
    nxt_evt  = hit & eif.een;
    nxt_irq  = |(nxt_pend & eif.ien);
  end

  // The first cycle after reset only primes the history, so a line already
  // high at reset does not look like a rising edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff  <= gpei_pkg::RST_LINES;
      pend_ff  <= gpei_pkg::RST_LINES;
      evt_ff   <= gpei_pkg::RST_LINES;
      irq_ff   <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      prev_ff  <= eif.lines;
      pend_ff  <= nxt_pend;
      evt_ff   <= nxt_evt;
      irq_ff   <= nxt_irq;
      armed_ff <= 1'b1;
    end
  end

  assign eif.pend = pend_ff;
  assign eif.evt  = evt_ff;
  assign eif.irq  = irq_ff;
endmodule
`default_nettype wire

// ===== testbench/gpei_port_props.sv
// Concurrent checks on the port's bus, pin and interrupt outputs.
`default_nettype none
module gpei_port_props #(
  parameter int NUM_PORTS = 8
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [15:0]                 pin_in,
  input wire logic [15:0]                 pin_out,
  input wire logic [15:0]                 pin_oe_n,
  input wire logic [15:0]                 pin_pu,
  input wire logic [15:0]                 pin_pd,
  input wire logic [(NUM_PORTS-1)*16-1:0] other_ports,
  input wire logic [7:0]                  int_evt,
  input wire logic [23:0]                 evt_out,
  input wire logic                        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr;
  logic [3:0] act_ff;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Only a completed write can clear pending bits or move enable bits.
  assign wr = psel & penable & pwrite;
  // History of recent input changes or writes; an interrupt needs one as its cause.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      act_ff <= 4'h0;
    else
      act_ff <= {act_ff[2:0],
                 $changed(int_evt) || $changed(pin_in) || $changed(other_ports) || wr};
  end
  // Bus phases.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_hole;
    s_setup ##0 (paddr == 8'h1C || paddr > 8'h3C);
  endsequence
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no ready in the access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_hole_error: assert property (s_hole |=> pready && pslverr)
    else $error("unmapped access answered without error");
  a_int_cause: assert property ((evt_out[23:16] & ~($past(int_evt) ^ $past(int_evt, 2))) == 8'h00)
    else $error("internal line event without a change of its source");
  a_pull_excl: assert property ((pin_pu & pin_pd) == 16'h0000)
    else $error("pull-up and pull-down both on");
  a_pin_hold: assert property ($changed({pin_out, pin_oe_n}) |=> $stable({pin_out, pin_oe_n}) [*7])
    else $error("pin outputs refreshed faster than allowed");
  a_irq_cause: assert property ($rose(irq) |-> act_ff != 4'h0)
    else $error("interrupt rose without a cause");
  a_irq_drop: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt fell without a software write");
endmodule

bind gpei_port gpei_port_props #(.NUM_PORTS(NUM_PORTS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_pu(pin_pu), .pin_pd(pin_pd), .other_ports(other_ports),
  .int_evt(int_evt), .evt_out(evt_out), .irq(irq)
);
`default_nettype wire

// ===== testbench/gpei_pad_model.sv
// Pad model: resolves each pin from the port's driver, its pulls and the outside world.
`default_nettype none
module gpei_pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] pin_pu,
  input  wire logic [15:0] pin_pd,
  input  wire logic [15:0] ext,
  output var  logic [15:0] pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin with no pull follows the outside level, which the bench sets once to a random value.
  assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pu | (~pin_pd & ext)));
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the GPIO port with edge interrupt controller.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         pready, pslverr, irq, last_err;
  logic [7:0]   paddr = 8'h00, int_evt = 8'h00;
  logic [15:0]  ext = 16'h0000, pin_in, pin_out, pin_oe_n, pin_pu, pin_pd;
  logic [23:0]  evt_out, mk, evt_seen = 24'h000000, tmask = 24'h000000;
  logic [31:0]  pwdata = 32'h00000000, prdata, rd, d, map;
  logic [63:0]  af_src = 64'h0;
  logic [111:0] oth = 112'h0;
  int           errors = 0, samples_checked = 0, cyc = 0, seed = 55, k, j, p;
  gpei_port #(.NUM_PORTS(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu),
    .pin_pd(pin_pd), .af_src(af_src), .other_ports(oth), .int_evt(int_evt),
    .evt_out(evt_out), .irq(irq)
  );
  gpei_pad_model pads (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pu(pin_pu), .pin_pd(pin_pd), .ext(ext),
    .pad(pin_in)
  );
  // Clock of 8 ns period.
  initial
  begin
    forever #4 pclk = ~pclk;
  end
  // Event pulses are gathered here; the cycle ceiling cuts a hang short.
  always @(posedge pclk)
  begin
    evt_seen <= evt_seen | evt_out;
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      stop_test();
    end
  end
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Holds reset for ten cycles.
  task automatic reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // One bus transfer; the request stands until ready is seen, then a free cycle follows.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench's cycle ceiling ends a wait for ready.
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  // Pin level each source selection should put out.
  function automatic logic [15:0] af_exp(input logic [63:0] s, input logic [31:0] m);
    logic [15:0] r;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = s[m[2 * i +: 2] * 16 + i];
    end
    return r;
  endfunction
  // Main sequence.
  initial
  begin
    reset();
    chk(pin_oe_n, 32'h0000FFFF);
    rdchk(gpei_pkg::OFS_MODE, gpei_pkg::RST_WORD);
    rdchk(gpei_pkg::OFS_PEND, gpei_pkg::RST_WORD);
    rdchk(8'h1C, 32'h00000000);
    chk(last_err, 1'b1);
    done("reset");
    apb(1'b1, gpei_pkg::OFS_MODE, 32'h55555555);
    d = $random(seed);
    apb(1'b1, gpei_pkg::OFS_ODR, {16'h0000, d[15:0]});
    repeat (9) @(posedge pclk);
    chk(pin_out, d[15:0]);
    chk(pin_oe_n, 32'h00000000);
    apb(1'b1, gpei_pkg::OFS_OTYPE, 32'h0000FFFF);
    repeat (9) @(posedge pclk);
    chk(pin_out, 32'h00000000);
    chk(pin_oe_n, {16'h0000, d[15:0]});
    done("outputs");
    apb(1'b1, gpei_pkg::OFS_MODE, gpei_pkg::RST_WORD);
    apb(1'b1, gpei_pkg::OFS_PULL, 32'h55555555);
    d = $random(seed);
    ext <= d[15:0];
    repeat (9) @(posedge pclk);
    chk(pin_pu, 32'h0000FFFF);
    rdchk(gpei_pkg::OFS_IDR, 32'h0000FFFF);
    apb(1'b1, gpei_pkg::OFS_PULL, 32'hAAAAAAAA);
    // Pull outputs follow one cycle after the write, the input register one more.
    @(posedge pclk);
    chk(pin_pd, 32'h0000FFFF);
    rdchk(gpei_pkg::OFS_IDR, 32'h00000000);
    apb(1'b1, gpei_pkg::OFS_PULL, gpei_pkg::RST_WORD);
    @(posedge pclk);
    rdchk(gpei_pkg::OFS_IDR, {16'h0000, ext});
    apb(1'b1, gpei_pkg::OFS_MODE, 32'hFFFFFFFF);
    rdchk(gpei_pkg::OFS_IDR, 32'h00000000);
    done("inputs");
    apb(1'b1, gpei_pkg::OFS_OTYPE, gpei_pkg::RST_WORD);
    apb(1'b1, gpei_pkg::OFS_MODE, 32'hAAAAAAAA);
    map = $random(seed);
    af_src <= {$random(seed), $random(seed)};
    apb(1'b1, gpei_pkg::OFS_AFMAP, map);
    repeat (9) @(posedge pclk);
    chk(pin_out, af_exp(af_src, map));
    apb(1'b1, gpei_pkg::OFS_LOCK, gpei_pkg::LOCK_KEY1);
    apb(1'b1, gpei_pkg::OFS_LOCK, gpei_pkg::LOCK_KEY2);
    rdchk(gpei_pkg::OFS_LOCK, 32'h00000001);
    apb(1'b1, gpei_pkg::OFS_MODE, gpei_pkg::RST_WORD);
    apb(1'b1, gpei_pkg::OFS_AFMAP, ~map);
    apb(1'b1, gpei_pkg::OFS_LOCK, gpei_pkg::RST_WORD);
    rdchk(gpei_pkg::OFS_MODE, 32'hAAAAAAAA);
    rdchk(gpei_pkg::OFS_AFMAP, map);
    rdchk(gpei_pkg::OFS_LOCK, 32'h00000001);
    done("lock");
    // Rising only, falling only, both, then both with a one-cycle pulse.
    apb(1'b1, gpei_pkg::OFS_EEN, 32'h00FFFFFF);
    for (int m = 0; m < 4; m++)
    begin
      k = 16 + ($unsigned($random(seed)) % 8);
      j = k ^ 1;
      mk = (24'h000001 << k) | (24'h000001 << j);
      tmask = tmask | mk;
      apb(1'b1, gpei_pkg::OFS_RISE, (m != 1) ? mk : 24'h000000);
      apb(1'b1, gpei_pkg::OFS_FALL, (m != 0) ? mk : 24'h000000);
      apb(1'b1, gpei_pkg::OFS_IEN, 32'h00000001 << k);
      int_evt <= mk[23:16];
      if (m == 3)
      begin
        @(posedge pclk);
        int_evt <= 8'h00;
      end
      repeat (3) @(posedge pclk);
      rdchk(gpei_pkg::OFS_PEND, (m != 1) ? mk : 24'h000000);
      chk(irq, m != 1);
      apb(1'b1, gpei_pkg::OFS_PCLR, gpei_pkg::RST_WORD);
      rdchk(gpei_pkg::OFS_PEND, (m != 1) ? mk : 24'h000000);
      apb(1'b1, gpei_pkg::OFS_PCLR, 32'h00000001 << k);
      rdchk(gpei_pkg::OFS_PEND, (m != 1) ? (32'h00000001 << j) : 32'h00000000);
      chk(irq, 1'b0);
      apb(1'b1, gpei_pkg::OFS_PCLR, 32'h00FFFFFF);
      if (m < 3)
      begin
        int_evt <= 8'h00;
        repeat (3) @(posedge pclk);
        rdchk(gpei_pkg::OFS_PEND, (m != 0) ? mk : 24'h000000);
        apb(1'b1, gpei_pkg::OFS_PCLR, 32'h00FFFFFF);
      end
    end
    done("edges");
    p = 1 + ($unsigned($random(seed)) % 7);
    k = $unsigned($random(seed)) % 8;
    apb(1'b1, gpei_pkg::OFS_SRC0, {8{p[3:0]}});
    apb(1'b1, gpei_pkg::OFS_RISE, 32'h00000001 << k);
    apb(1'b1, gpei_pkg::OFS_FALL, gpei_pkg::RST_WORD);
    oth[(p - 1) * 16 + k] <= 1'b1;
    tmask[k] = 1'b1;
    repeat (4) @(posedge pclk);
    rdchk(gpei_pkg::OFS_PEND, 32'h00000001 << k);
    chk(evt_seen, tmask);
    done("lines");
    reset();
    rdchk(gpei_pkg::OFS_LOCK, gpei_pkg::RST_WORD);
    done("rereset");
    stop_test();
  end
endmodule
`default_nettype wire
